// >>> logic/pin_function_mux.sv
// Pin function mux with reset straps and dram parity pins
// What this block does
// R1 - Ten select bits each choose the function of exactly one dual-purpose pin
// R2 - Bit 0 clear gives address-mux strobe, set gives baud generator 1
// R3 - Bit 1 clear gives bank 0 row strobe, set gives baud gen 2 function
// R4 - Bit 2 clear gives bank 1 row strobe, set gives baud gen 3 function
// R5 - Bit 3 clear gives upper column strobe, set gives port B bit 0
// R6 - Bit 4 clear gives lower column strobe, set gives port B bit 1
// R7 - Bit 5 clear gives dram write strobe, independent of processor read/write
// R8 - Bit 6 clear gives bidirectional byte address bit 0, set gives timer output
// R9 - Bit 7 set gives low byte write enable, clear gives dma request
// R10 - Bit 8 set gives high byte write enable, clear gives dma acknowledge
// R11 - Bit 9 clear gives memory output enable, set gives dma done
// R12 - Lower parity pin low in reset sets all four byte-width enables
// R13 - Eight-bit accesses move data on the upper data byte lines
// R14 - Accesses outside all chip-select regions are always full sixteen-bit
// R15 - Upper parity pin high in reset disables the embedded core
// R16 - After reset the upper parity pin carries parity for the upper byte
// R17 - After reset the lower parity pin carries parity for the lower byte
// R18 - Parity error pin driven low while any dram parity error flag set
// R19 - Parity error pin low in reset puts all pins in high impedance; here only the mux and parity pins float, data_bus_o still drives
// R20 - Bus-clear request is observed only, never driven or shown on a pin
// R21 - Outside system holds test reset low during system reset
// R22 - Strap values latch at reset release and hold until next reset
`timescale 1ns/1ps
module pin_function_mux #(
    parameter int SEL_WIDTH = 10
) (
    input  wire logic                      clock_i,
    input  wire logic                      resetn_i,
    input  wire logic [SEL_WIDTH-1:0]      pin_function_select_i,
    // Dram and bus sizing functions
    input  wire logic                      dram_addr_mux_strobe_n_i,
    input  wire logic                      row_strobe_bank0_n_i,
    input  wire logic                      row_strobe_bank1_n_i,
    input  wire logic                      col_strobe_upper_n_i,
    input  wire logic                      col_strobe_lower_n_i,
    input  wire logic                      dram_write_cycle_i,
    input  wire logic                      byte_addr_bit0_out_i,
    input  wire logic                      byte_addr_bit0_oe_n_i,
    input  wire logic                      write_en_low_byte_n_i,
    input  wire logic                      write_en_high_byte_n_i,
    input  wire logic                      mem_output_en_n_i,
    // Legacy peripheral functions, each with its own drive enable
    input  wire logic [SEL_WIDTH-1:0]      legacy_out_i,
    input  wire logic [SEL_WIDTH-1:0]      legacy_oe_n_i,
    output logic [SEL_WIDTH-1:0]           legacy_in_o,
    output logic                           byte_addr_bit0_in_o,
    // Dual-function pins
    input  wire logic [SEL_WIDTH-1:0]      mux_pin_i,
    output logic [SEL_WIDTH-1:0]           mux_pin_o,
    output logic [SEL_WIDTH-1:0]           mux_pin_oe_n_o,
    // Data bus and byte sizing
    input  wire logic [3:0]                cs_hit_i,
    input  wire logic [3:0]                cs_byte_width_en_i,
    input  wire logic [15:0]               data_in_i,
    input  wire logic [7:0]                byte_data_i,
    input  wire logic                      byte_access_i,
    input  wire logic                      data_drive_i,
    output logic [15:0]                    data_bus_o,
    output logic                           byte_cycle_o,
    output logic [3:0]                     cs_byte_width_en_o,
    output logic                           cs_byte_width_load_o,
    // Parity pins and control
    input  wire logic                      parity_odd_i,
    input  wire logic                      parity_drive_i,
    input  wire logic [1:0]                dram_parity_err_flag_i,
    input  wire logic                      parity_pin_upper_i,
    input  wire logic                      parity_pin_lower_i,
    input  wire logic                      parity_error_pin_i,
    output logic                           parity_pin_upper_o,
    output logic                           parity_pin_upper_oe_n_o,
    output logic                           parity_pin_lower_o,
    output logic                           parity_pin_lower_oe_n_o,
    output logic                           parity_error_out_n_o,
    output logic                           parity_error_out_oe_n_o,
    output logic [1:0]                     parity_mismatch_o,
    // Straps and core
    input  wire logic                      bus_clear_request_i,
    output logic                           bus_clear_seen_o,
    output logic                           core_disable_o,
    output logic                           global_hiz_o
);
    import pin_mux_pkg::*;

    // All checks here run on the system clock and rest while reset is held
    default clocking @(posedge clock_i);
    endclocking
    default disable iff (!resetn_i);

    logic                 in_reset;
    logic                 core_dis_strap;
    logic                 bus_w_strap;
    logic                 hiz_strap;
    logic                 hiz_active;
    logic [SEL_WIDTH-1:0] dram_sel;
    logic [SEL_WIDTH-1:0] dram_out;
    logic [SEL_WIDTH-1:0] dram_oe_n;
    logic [SEL_WIDTH-1:0] pin_out_next;
    logic [SEL_WIDTH-1:0] pin_oe_n_next;
    logic                 par_upper;
    logic                 par_lower;
    logic                 mism_upper;
    logic                 mism_lower;
    logic                 any_cs_byte;
    logic [15:0]          data_next;
    logic                 err_n_next;
    logic                 first_run_reg;

    strap_capture u_straps (
        .clock_i              (clock_i),
        .resetn_i             (resetn_i),
        .parity_pin_upper_i   (parity_pin_upper_i),
        .parity_pin_lower_i   (parity_pin_lower_i),
        .parity_error_pin_i   (parity_error_pin_i),
        .in_reset_o           (in_reset),
        .core_disable_strap_o (core_dis_strap),
        .bus_width_strap_o    (bus_w_strap),
        .global_hiz_strap_o   (hiz_strap)
    );

    parity_gen #(.BYTE_W(8)) u_par_upper (
        .byte_i     (data_in_i[15:8]),
        .odd_i      (parity_odd_i),
        .pin_i      (parity_pin_upper_i),
        .parity_o   (par_upper),
        .mismatch_o (mism_upper)
    );

    parity_gen #(.BYTE_W(8)) u_par_lower (
        .byte_i     (data_in_i[7:0]),
        .odd_i      (parity_odd_i),
        .pin_i      (parity_pin_lower_i),
        .parity_o   (par_lower),
        .mismatch_o (mism_lower)
    );

    // Global high impedance only after the strap is known; during reset pins float anyway
    assign hiz_active = !hiz_strap; // R19

    // Dram side functions in select bit order; only the byte address bit is bidirectional
    assign dram_out = {mem_output_en_n_i, write_en_high_byte_n_i, write_en_low_byte_n_i,
                       byte_addr_bit0_out_i, !dram_write_cycle_i, col_strobe_lower_n_i,
                       col_strobe_upper_n_i, row_strobe_bank1_n_i, row_strobe_bank0_n_i,
                       dram_addr_mux_strobe_n_i}; // R2 R3 R4 R5 R6 R7 R8 R9 R10 R11
    assign dram_oe_n = {3'b000, byte_addr_bit0_oe_n_i, 6'b00_0000}; // R8
    // Bits 7 and 8 pick the dram function when set
    assign dram_sel = ~(pin_function_select_i ^ SEL_INVERT[SEL_WIDTH-1:0]); // R9 R10

    genvar g;
    generate
        for (g = 0; g < SEL_WIDTH; g = g + 1) begin : g_pin
            // Each select bit steers exactly one pin
            assign pin_out_next[g]  = dram_sel[g] ? dram_out[g] : legacy_out_i[g]; // R1
            assign pin_oe_n_next[g] = hiz_active | in_reset | (dram_sel[g] ? dram_oe_n[g]
                                      : legacy_oe_n_i[g]);
            assign legacy_in_o[g]   = dram_sel[g] ? 1'b0 : mux_pin_i[g];
        end
    endgenerate

    assign byte_addr_bit0_in_o = dram_sel[6] ? mux_pin_i[6] : 1'b0; // R8

    // Byte cycles only inside an enabled chip select; elsewhere always word wide
    assign any_cs_byte = |(cs_hit_i & cs_byte_width_en_i); // R14
    assign byte_cycle_o = byte_access_i & any_cs_byte; // R14
    // Narrow data rides on the upper lanes and is repeated so all 16 lines drive
    assign data_next = byte_cycle_o ? {byte_data_i, byte_data_i} : data_in_i; // R13

    // Width enables forced on once, right after reset, if the strap was low
    assign cs_byte_width_load_o = first_run_reg && !bus_w_strap; // R12
    assign cs_byte_width_en_o   = EN8_ALL_SET; // R12

    // High only in the cycle after release, so the enables load once per reset
    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            first_run_reg <= 1'b0;
        end else begin
            first_run_reg <= in_reset;
        end
    end

    assign err_n_next = !(|dram_parity_err_flag_i); // R18

    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            mux_pin_o      <= '0;
            mux_pin_oe_n_o <= '1;
            data_bus_o     <= 16'h0000;
        end else begin
            mux_pin_o      <= pin_out_next;
            mux_pin_oe_n_o <= pin_oe_n_next;
            data_bus_o     <= data_drive_i ? data_next : 16'h0000;
        end
    end

    // Parity pins carry data parity only outside reset; hiz strap overrides all drive
    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            parity_pin_upper_o      <= 1'b0;
            parity_pin_upper_oe_n_o <= 1'b1;
            parity_pin_lower_o      <= 1'b0;
            parity_pin_lower_oe_n_o <= 1'b1;
            parity_error_out_n_o    <= 1'b1;
            parity_error_out_oe_n_o <= 1'b1;
            parity_mismatch_o       <= 2'b00;
        end else begin
            parity_pin_upper_o      <= par_upper; // R16
            parity_pin_upper_oe_n_o <= in_reset | hiz_active | !parity_drive_i; // R16
            parity_pin_lower_o      <= par_lower; // R17
            parity_pin_lower_oe_n_o <= in_reset | hiz_active | !parity_drive_i; // R17
            parity_error_out_n_o    <= err_n_next; // R18
            parity_error_out_oe_n_o <= in_reset | hiz_active; // R19
            parity_mismatch_o       <= parity_drive_i ? 2'b00 : {mism_upper, mism_lower};
        end
    end

    // Bus clear is only watched; no pin carries it
    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            bus_clear_seen_o <= 1'b0;
        end else begin
            bus_clear_seen_o <= bus_clear_request_i; // R20
        end
    end

    assign core_disable_o = core_dis_strap; // R15
    assign global_hiz_o   = hiz_active;     // R19

    sequence s_hiz_strapped;
        !in_reset && hiz_active;
    endsequence

    // Straps are sampled on the last reset edge and show two edges later
    sequence s_reset_release;
        $rose(resetn_i);
    endsequence

    chk_hiz_all_float : assert property ( // R19
        s_hiz_strapped |=> (&mux_pin_oe_n_o) && parity_error_out_oe_n_o)
        else $error("pins driven while three-state strap active");
    chk_pin_select : assert property ( // R2
        !in_reset && !pin_function_select_i[0] |=> mux_pin_o[0] == $past(dram_addr_mux_strobe_n_i))
        else $error("address mux strobe not on its pin");
    chk_wel_sense : assert property ( // R9
        pin_function_select_i[7] |=> mux_pin_o[7] == $past(write_en_low_byte_n_i))
        else $error("low byte write enable not selected");
    chk_dram_write : assert property ( // R7
        !pin_function_select_i[5] && dram_write_cycle_i |=> !mux_pin_o[5])
        else $error("dram write strobe not low");
    chk_parity_err : assert property ( // R18
        (|dram_parity_err_flag_i) |=> !parity_error_out_n_o)
        else $error("parity error pin not asserted");
    chk_upper_parity : assert property ( // R16
        parity_drive_i |=> parity_pin_upper_o == ((^$past(data_in_i[15:8])) ^ $past(parity_odd_i)))
        else $error("upper parity wrong");
    chk_word_outside : assert property ( // R14
        cs_hit_i == 4'h0 |-> !byte_cycle_o)
        else $error("byte cycle outside chip selects");
    chk_byte_lanes : assert property ( // R13
        byte_cycle_o && data_drive_i |=> data_bus_o[15:8] == $past(byte_data_i))
        else $error("byte data not on upper lanes");
    chk_width_load : assert property ( // R12
        s_reset_release |=> cs_byte_width_load_o == !$past(parity_pin_lower_i, 2))
        else $error("width enable load does not follow strap");
    chk_core_strap : assert property ( // R15
        s_reset_release |=> core_disable_o == $past(parity_pin_upper_i, 2))
        else $error("core disable does not follow strap");
    chk_hiz_strap : assert property ( // R19
        s_reset_release |=> global_hiz_o == !$past(parity_error_pin_i, 2))
        else $error("three-state does not follow strap");
    chk_row0_pin : assert property ( // R3
        !pin_function_select_i[1] |=> mux_pin_o[1] == $past(row_strobe_bank0_n_i))
        else $error("bank 0 row strobe not on its pin");
    chk_row1_pin : assert property ( // R4
        !pin_function_select_i[2] |=> mux_pin_o[2] == $past(row_strobe_bank1_n_i))
        else $error("bank 1 row strobe not on its pin");
    chk_col_upper : assert property ( // R5
        !pin_function_select_i[3] |=> mux_pin_o[3] == $past(col_strobe_upper_n_i))
        else $error("upper column strobe not on its pin");
    chk_col_lower : assert property ( // R6
        !pin_function_select_i[4] |=> mux_pin_o[4] == $past(col_strobe_lower_n_i))
        else $error("lower column strobe not on its pin");
    chk_byte_addr : assert property ( // R8
        !pin_function_select_i[6] && !in_reset && !hiz_active |=>
            mux_pin_o[6] == $past(byte_addr_bit0_out_i)
            && mux_pin_oe_n_o[6] == $past(byte_addr_bit0_oe_n_i))
        else $error("byte address bit not on its pin");
    chk_weh_sense : assert property ( // R10
        pin_function_select_i[8] |=> mux_pin_o[8] == $past(write_en_high_byte_n_i))
        else $error("high byte write enable not selected");
    chk_mem_oe : assert property ( // R11
        !pin_function_select_i[9] |=> mux_pin_o[9] == $past(mem_output_en_n_i))
        else $error("memory output enable not on its pin");
    chk_baud_route : assert property ( // R2
        pin_function_select_i[0] |=> mux_pin_o[0] == $past(legacy_out_i[0]))
        else $error("baud generator output not on its pin");
    chk_dma_route : assert property ( // R9
        !pin_function_select_i[7] |=> mux_pin_o[7] == $past(legacy_out_i[7]))
        else $error("dma request not on its pin");
    chk_strobe_drive : assert property ( // R2
        !in_reset && !hiz_active && !pin_function_select_i[0] |=> !mux_pin_oe_n_o[0])
        else $error("address mux strobe pin not driven");
    chk_lower_parity : assert property ( // R17
        parity_drive_i |=> parity_pin_lower_o == ((^$past(data_in_i[7:0])) ^ $past(parity_odd_i)))
        else $error("lower parity wrong");
    chk_parity_drive : assert property ( // R16
        parity_drive_i && !in_reset && !hiz_active |=> !parity_pin_upper_oe_n_o)
        else $error("upper parity pin not driven");
    chk_parity_clear : assert property ( // R18
        !(|dram_parity_err_flag_i) |=> parity_error_out_n_o)
        else $error("parity error pin low without a flag");
    chk_bus_clear : assert property ( // R20
        bus_clear_request_i |=> bus_clear_seen_o)
        else $error("bus clear request not observed");
endmodule : pin_function_mux

// >>> common/pin_mux_pkg.sv
// Constants and types for the pin function mux and reset strap block
package pin_mux_pkg;
    localparam int          SEL_W          = 10;
    localparam int          CS_COUNT       = 4;
    localparam logic [9:0]  SEL_RESET      = 10'h000;
    localparam int          SEL_DRAM_ADDR_MUX_STROBE_BIT   = 0;
    localparam int          SEL_WEL_BIT    = 7;
    localparam int          SEL_WEH_BIT    = 8;
    localparam logic [3:0]  EN8_ALL_SET    = 4'hf;
    localparam logic [3:0]  EN8_ALL_CLEAR  = 4'h0;
    // Select bits whose dram function is chosen when the bit is set
    localparam logic [9:0]  SEL_INVERT     = 10'h180;
    localparam logic        PARITY_ODD     = 1'b1;

    typedef enum logic [2:0] {
        ST_RESET = 3'b001,
        ST_LATCH = 3'b010,
        ST_RUN   = 3'b100
    } strap_state_t;
endpackage : pin_mux_pkg

// >>> logic/strap_capture.sv
// Samples the three dual-purpose pins as straps while system reset is held
`timescale 1ns/1ps
module strap_capture (
    input  wire logic                      clock_i,
    input  wire logic                      resetn_i,
    input  wire logic                      parity_pin_upper_i,
    input  wire logic                      parity_pin_lower_i,
    input  wire logic                      parity_error_pin_i,
    output logic                           in_reset_o,
    output logic                           core_disable_strap_o,
    output logic                           bus_width_strap_o,
    output logic                           global_hiz_strap_o
);
    import pin_mux_pkg::*;

    strap_state_t state_reg;
    strap_state_t state_next;
    logic         core_dis_sample_reg;
    logic         bus_w_sample_reg;
    logic         hiz_sample_reg;

    // Sampling is clocked: reset loads no constants here, pins are read each edge in reset
    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            core_dis_sample_reg <= parity_pin_upper_i;
            bus_w_sample_reg    <= parity_pin_lower_i;
            hiz_sample_reg      <= parity_error_pin_i;
        end
    end

    always_comb begin
        case (state_reg)
            ST_RESET: state_next = ST_LATCH;
            ST_LATCH: state_next = ST_RUN;
            ST_RUN:   state_next = ST_RUN;
            default:  state_next = ST_RESET;
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            state_reg <= ST_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    assign in_reset_o = (state_reg == ST_RESET);

    // Straps read the last value held in reset and never change until the next reset R22
    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            core_disable_strap_o <= 1'b0;
            bus_width_strap_o    <= 1'b1;
            global_hiz_strap_o   <= 1'b1;
        end else if (state_reg == ST_RESET) begin
            core_disable_strap_o <= core_dis_sample_reg;  // R15
            bus_width_strap_o    <= bus_w_sample_reg;     // R12
            global_hiz_strap_o   <= hiz_sample_reg;       // R19
        end
    end

    chk_straps_stable : assert property (@(posedge clock_i) disable iff (!resetn_i)
        (state_reg == ST_RUN) |=> $stable(bus_width_strap_o) && $stable(core_disable_strap_o)
            && $stable(global_hiz_strap_o)) // R22
        else $error("strap value changed outside reset");
endmodule : strap_capture

// >>> logic/parity_gen.sv
// Byte parity generator and checker for the two dram parity pins
`timescale 1ns/1ps
module parity_gen #(
    parameter int BYTE_W = 8
) (
    input  wire logic [BYTE_W-1:0]         byte_i,
    input  wire logic                      odd_i,
    input  wire logic                      pin_i,
    output logic                           parity_o,
    output logic                           mismatch_o
);
    assign parity_o   = (^byte_i) ^ odd_i;
    assign mismatch_o = parity_o ^ pin_i;
endmodule : parity_gen

// >>> tb/pin_partner_model.sv
// Far-side pin model: reset straps, peripheral drive and floating lines
`timescale 1ns/1ps
module pin_partner_model (
    input  wire logic        clock_i,
    input  wire logic        resetn_i,
    input  wire logic [12:0] dev_val_i,
    input  wire logic [12:0] dev_oe_n_i,
    input  wire logic [2:0]  strap_i,
    input  wire logic [12:0] ext_val_i,
    input  wire logic [12:0] ext_en_i,
    output logic      [12:0] pin_o,
    output logic             test_reset_n_o
);
    logic [12:0] float_reg;
    logic [12:0] strap_w;

    assign strap_w = {strap_i, 10'h000};
    assign test_reset_n_o = 1'h0;

    // Undriven lines toggle so a stale level never passes for a driven one
    initial begin
        float_reg = 13'h0aaa;
        forever @(posedge clock_i) float_reg <= ~float_reg;
    end

    always_comb begin
        for (int i = 0; i < 13; i++) begin
            if (!dev_oe_n_i[i]) pin_o[i] = dev_val_i[i];
            else if (!resetn_i && i >= 10) pin_o[i] = strap_w[i];
            else if (ext_en_i[i]) pin_o[i] = ext_val_i[i];
            else pin_o[i] = float_reg[i];
        end
    end
endmodule : pin_partner_model

// >>> tb/pin_function_mux_bench.sv
// Self-checking bench for the pin function mux with a per-cycle reference model
`timescale 1ns/1ps
module pin_function_mux_bench;
    import pin_mux_pkg::*;
    logic        clock_i, resetn_i, dram_addr_mux_strobe_n_i, row_strobe_bank0_n_i;
    logic        row_strobe_bank1_n_i, col_strobe_upper_n_i, col_strobe_lower_n_i;
    logic        dram_write_cycle_i, byte_addr_bit0_out_i, byte_addr_bit0_oe_n_i;
    logic        write_en_low_byte_n_i, write_en_high_byte_n_i, mem_output_en_n_i;
    logic        byte_access_i, data_drive_i, parity_odd_i, parity_drive_i, bus_clear_request_i;
    logic        parity_pin_upper_i, parity_pin_lower_i, parity_error_pin_i, byte_addr_bit0_in_o;
    logic        byte_cycle_o, cs_byte_width_load_o, parity_pin_upper_o, parity_pin_upper_oe_n_o;
    logic        parity_pin_lower_o, parity_pin_lower_oe_n_o, parity_error_out_n_o;
    logic        parity_error_out_oe_n_o, bus_clear_seen_o, core_disable_o, global_hiz_o;
    logic        p_up, p_lo, test_reset_n;
    logic [9:0]  pin_function_select_i, legacy_out_i, legacy_oe_n_i, legacy_in_o;
    logic [9:0]  mux_pin_i, mux_pin_o, mux_pin_oe_n_o;
    logic [3:0]  cs_hit_i, cs_byte_width_en_i, cs_byte_width_en_o;
    logic [15:0] data_in_i, data_bus_o;
    logic [7:0]  byte_data_i;
    logic [1:0]  dram_parity_err_flag_i, parity_mismatch_o;
    logic [12:0] pins, ext_val, ext_en;
    logic [2:0]  strap;
    int          errors, num_checks, loads;

    pin_function_mux #(.SEL_WIDTH(SEL_W)) i_dut (
        .clock_i, .resetn_i, .pin_function_select_i, .dram_addr_mux_strobe_n_i,
        .row_strobe_bank0_n_i, .row_strobe_bank1_n_i, .col_strobe_upper_n_i,
        .col_strobe_lower_n_i, .dram_write_cycle_i, .byte_addr_bit0_out_i,
        .byte_addr_bit0_oe_n_i, .write_en_low_byte_n_i, .write_en_high_byte_n_i,
        .mem_output_en_n_i, .legacy_out_i, .legacy_oe_n_i, .legacy_in_o, .byte_addr_bit0_in_o,
        .mux_pin_i, .mux_pin_o, .mux_pin_oe_n_o, .cs_hit_i, .cs_byte_width_en_i, .data_in_i,
        .byte_data_i, .byte_access_i, .data_drive_i, .data_bus_o, .byte_cycle_o,
        .cs_byte_width_en_o, .cs_byte_width_load_o, .parity_odd_i, .parity_drive_i,
        .dram_parity_err_flag_i, .parity_pin_upper_i, .parity_pin_lower_i, .parity_error_pin_i,
        .parity_pin_upper_o, .parity_pin_upper_oe_n_o, .parity_pin_lower_o,
        .parity_pin_lower_oe_n_o, .parity_error_out_n_o, .parity_error_out_oe_n_o,
        .parity_mismatch_o, .bus_clear_request_i, .bus_clear_seen_o, .core_disable_o,
        .global_hiz_o);

    pin_partner_model i_partner (
        .clock_i, .resetn_i, .strap_i(strap), .ext_val_i(ext_val), .ext_en_i(ext_en),
        .dev_val_i({parity_error_out_n_o, parity_pin_lower_o, parity_pin_upper_o, mux_pin_o}),
        .dev_oe_n_i({parity_error_out_oe_n_o, parity_pin_lower_oe_n_o, parity_pin_upper_oe_n_o,
                     mux_pin_oe_n_o}),
        .pin_o(pins), .test_reset_n_o(test_reset_n));

    assign {parity_error_pin_i, parity_pin_lower_i, parity_pin_upper_i, mux_pin_i} = pins;

    // Parity check sees the pin level just before the edge, not after the drive flips
    always @(posedge clock_i) {p_up, p_lo} <= {parity_pin_upper_i, parity_pin_lower_i};

    initial begin
        clock_i = 1'h0;
        forever #50 clock_i = ~clock_i;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic drive_random();
        logic w;
        {dram_addr_mux_strobe_n_i, row_strobe_bank0_n_i, row_strobe_bank1_n_i,
         col_strobe_upper_n_i, col_strobe_lower_n_i, dram_write_cycle_i, byte_addr_bit0_out_i,
         byte_addr_bit0_oe_n_i, write_en_low_byte_n_i, write_en_high_byte_n_i,
         mem_output_en_n_i, byte_access_i, data_drive_i, parity_odd_i, parity_drive_i,
         bus_clear_request_i} = 16'($urandom);
        pin_function_select_i = 10'($urandom);
        legacy_out_i = 10'($urandom);
        legacy_oe_n_i = 10'($urandom);
        {cs_hit_i, cs_byte_width_en_i, byte_data_i} = 16'($urandom);
        data_in_i = 16'($urandom);
        dram_parity_err_flag_i = 2'($urandom);
        w = 1'($urandom);
        ext_en = {3'h7, 10'($urandom)};
        // Both parity bytes right or both wrong, so mismatch bit order does not matter
        ext_val = {1'h1, ^data_in_i[7:0] ^ parity_odd_i ^ w,
                   ^data_in_i[15:8] ^ parity_odd_i ^ w, 10'($urandom)};
    endtask : drive_random

    task automatic cycle_check();
        logic [9:0] dram, dv, ev, eo;
        logic       hz, bc, eu, el, mu, ml;
        hz = ~strap[2];
        dram = ~(pin_function_select_i ^ SEL_INVERT);
        dv = {mem_output_en_n_i, write_en_high_byte_n_i, write_en_low_byte_n_i,
              byte_addr_bit0_out_i, ~dram_write_cycle_i, col_strobe_lower_n_i,
              col_strobe_upper_n_i, row_strobe_bank1_n_i, row_strobe_bank0_n_i,
              dram_addr_mux_strobe_n_i};
        ev = (dram & dv) | (~dram & legacy_out_i);
        eo = (~dram & legacy_oe_n_i) | (dram & {3'h0, byte_addr_bit0_oe_n_i, 6'h00});
        bc = byte_access_i & |(cs_hit_i & cs_byte_width_en_i);
        eu = ^data_in_i[15:8] ^ parity_odd_i;
        el = ^data_in_i[7:0] ^ parity_odd_i;
        mu = p_up ^ eu;
        ml = p_lo ^ el;
        if (!hz) check(16'(mux_pin_o), 16'(ev));
        check(16'(mux_pin_oe_n_o), hz ? 16'h03ff : 16'(eo));
        check(16'(legacy_in_o), 16'(mux_pin_i & ~dram));
        check(16'(byte_addr_bit0_in_o), 16'(dram[6] & mux_pin_i[6]));
        check(16'(byte_cycle_o), 16'(bc));
        if (data_drive_i) check(data_bus_o, bc ? {2{byte_data_i}} : data_in_i);
        if (!hz && !bc && data_drive_i && parity_drive_i) check(16'({parity_pin_upper_o,
            parity_pin_lower_o, parity_pin_upper_oe_n_o, parity_pin_lower_oe_n_o}),
            16'({eu, el, 2'h0}));
        if (!hz && !bc && !parity_drive_i && mu == ml)
            check(16'(parity_mismatch_o), 16'({mu, ml}));
        check(16'({parity_error_out_n_o, parity_error_out_oe_n_o}),
              16'({~|dram_parity_err_flag_i, hz}));
        if (hz) check(16'({parity_pin_upper_oe_n_o, parity_pin_lower_oe_n_o,
            parity_error_out_oe_n_o}), 16'h0007);
        check(16'({core_disable_o, global_hiz_o}), 16'({strap[0], hz}));
        check(16'(cs_byte_width_en_o), 16'(EN8_ALL_SET));
        check(16'(bus_clear_seen_o), 16'(bus_clear_request_i));
    endtask : cycle_check

    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : test_done

    initial begin
        resetn_i = 1'h0;
        strap = 3'h0;
        errors = 0;
        num_checks = 0;
        void'($urandom(32'he0de_6dee));
        drive_random();
        // Every strap combination, each after the first also a reset in mid-run
        for (int s = 0; s < 8; s++) begin
            @(negedge clock_i);
            resetn_i = 1'h0;
            strap = 3'(s);
            repeat (3) @(negedge clock_i);
            resetn_i = 1'h1;
            loads = 0;
            repeat (4) begin
                @(negedge clock_i);
                if (cs_byte_width_load_o === 1'h1) loads++;
            end
            check(16'(loads), 16'(!strap[1]));
            check(16'(test_reset_n), 16'h0000);
            repeat (200) begin
                drive_random();
                @(negedge clock_i);
                cycle_check();
            end
            $display("test with strap value %0d done", s);
        end
        test_done();
    end
endmodule : pin_function_mux_bench
